// ==== logic/smp_master_port.sv ====
// Byte-wide synchronous serial port, master and slave, with receive FIFO
// Overview of operation
// - Four pins: master-out data, master-in data, serial clock, active-low select.
// - Each byte travels most significant bit first in both directions.
// - Full duplex exchange, both directions timed by the master's serial clock.
// - Received byte replaces the sent byte in one register; one done flag.
// - Polarity and phase bits pick one of four timings; both ends match.
// - As slave, serial clock up to one eighth of the CPU clock.
// - Master offers four serial clock rates from two rate-select bits.
// - Master generates the serial clock and drives it out.
// - As master, enable and master bits stay set only while select input is high.
// - As master, MOSI is data output and MISO is data input.
// - Master transfer starts when software writes the data register while the receive FIFO is not full.
// - Data write loads the shift register in parallel, then shifts out.
// - Hardware sets the transfer-done flag at the end of each byte.
// - Interrupt only if port interrupt enabled and global mask clear.
// - At completion the received byte is pushed into the receive FIFO, whose head is the receive buffer.
// - Data register read returns the receive buffer, not the shifter.
// - Done flag clears after status access while set, then data read.
// - While done flag set, data writes ignored until status is read.
// - A byte is exactly eight clock pulses, shifting out and in together.
// - Write during a transfer is dropped, sets collision flag, no interrupt.
// - Master select low sets mode fault, clears enable and master bits.
`timescale 1ns/1ps
module smp_master_port (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_dr_wr,
  input wire logic [7:0] i_dr_wdata,
  input wire logic i_dr_rd,
  input wire logic i_sr_access,
  input wire logic i_cr_wr,
  input wire smp_pkg::smp_ctrl_s i_cr_wdata,
  input wire logic i_global_irq_mask,
  output logic [7:0] o_rx_data,
  output smp_pkg::smp_ctrl_s o_ctrl,
  output smp_pkg::smp_status_s o_status,
  output logic o_irq,
  output logic o_busy,
  input wire logic i_sck,
  output logic o_sck,
  output logic o_sck_oe,
  input wire logic i_mosi,
  output logic o_mosi,
  output logic o_mosi_oe,
  input wire logic i_miso,
  output logic o_miso,
  output logic o_miso_oe,
  input wire logic i_ss_n
);
  import smp_pkg::*;

  logic rst_meta_q;
  logic rst_q;
  smp_pins_s pins_s1_q;
  smp_pins_s pins_q;
  logic sck_prev_q;
  smp_state_e state_q;
  smp_state_e state_d;
  smp_ctrl_s ctrl_q;
  smp_ctrl_s ctrl_d;
  logic [7:0] sr_q;
  logic [7:0] sr_d;
  logic out_q;
  logic [3:0] edge_cnt_q;
  logic [2:0] samp_cnt_q;
  logic sck_q;
  logic sck_d;
  logic done_q;
  logic write_collision_flag_q;
  logic mode_fault_flag_q;
  logic armed_q;
  logic mf_armed_q;
  logic irq_q;
  logic busy_q;
  logic sck_oe_q;
  logic mosi_oe_q;
  logic miso_oe_q;
  logic [7:0] rx_q;
  logic m_tick;
  logic f_in_ready;
  logic f_out_valid;
  logic [7:0] f_out_data;

  // Reset release through two flops
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_meta_q <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_q <= rst_meta_q;
    end
  end

  // Pin synchronisers; only the second stage is looked at
  always_ff @(posedge i_ref_clk or negedge rst_q) begin
    if (!rst_q) begin
      pins_s1_q <= SMP_PINS_RESET;
      pins_q <= SMP_PINS_RESET;
      sck_prev_q <= 1'b0;
    end else begin
      pins_s1_q <= '{sck: i_sck, mosi: i_mosi, miso: i_miso, ss_n: i_ss_n};
      pins_q <= pins_s1_q;
      sck_prev_q <= pins_q.sck;
    end
  end

  wire master_on = ctrl_q.port_enable_bit && ctrl_q.master_select_bit;
  wire slave_on = ctrl_q.port_enable_bit && !ctrl_q.master_select_bit;
  wire ss_low = !pins_q.ss_n;
  wire in_master = (state_q == SMP_MASTER);
  wire in_slave = (state_q == SMP_SLAVE);
  wire in_idle = (state_q == SMP_IDLE);

  // Select pulled low on an enabled master is a fault; partner must keep it high
  wire fault = master_on && ss_low;

  // Slave sees edges of the sampled clock; MISO moves three reference cycles after an edge, so eight per period suffice
  wire s_edge = in_slave && (pins_q.sck != sck_prev_q);
  wire s_lead = pins_q.sck != ctrl_q.clock_idle_level;
  wire is_lead = in_master ? (edge_cnt_q[0] == 1'b0) : s_lead;
  wire any_edge = (in_master && m_tick) || s_edge;
  wire samp_on_lead = !ctrl_q.clock_sample_phase;
  wire sample_ev = any_edge && (is_lead == samp_on_lead);
  wire shift_ev = any_edge && (is_lead != samp_on_lead);
  wire data_in = in_master ? pins_q.miso : pins_q.mosi;

  wire master_done = in_master && m_tick && (edge_cnt_q == SMP_EDGE_LAST);
  wire slave_done = sample_ev && in_slave && (samp_cnt_q == SMP_SAMPLE_LAST);
  wire done_ev = (master_done && !fault) || slave_done;

  // Writes are held off while done is set and status not yet read
  wire wr_blocked = done_q && !armed_q;
  wire wr_busy = !in_idle || (slave_on && ss_low);
  wire collision = i_dr_wr && !wr_blocked && wr_busy;
  wire wr_take = i_dr_wr && !wr_blocked && !wr_busy && ctrl_q.port_enable_bit;
  wire start_master = wr_take && master_on && f_in_ready && !fault;
  wire load = wr_take && (slave_on || start_master);
  wire enter_slave = in_idle && slave_on && ss_low;

  // Serial clock tick source
  smp_rate_div u_rate_div (
    .i_clk(i_ref_clk),
    .i_rst_n(rst_q),
    .i_run(in_master),
    .i_rate_sel({ctrl_q.rate_select_hi, ctrl_q.rate_select_lo}),
    .o_tick(m_tick)
  );

  // Received bytes queue here; the head is the receive buffer
  smp_fifo #(
    .WIDTH(SMP_DATA_W),
    .DEPTH(SMP_FIFO_DEPTH)
  ) u_rx_fifo (
    .i_clk(i_ref_clk),
    .i_rst_n(rst_q),
    .i_in_valid(done_ev),
    .o_in_ready(f_in_ready),
    .i_in_data(sr_d),
    .o_out_valid(f_out_valid),
    .i_out_ready(i_dr_rd),
    .o_out_data(f_out_data)
  );

  // Shift register: parallel load, shift in on sample edges, MSB first
  always_comb begin
    sr_d = sr_q;
    if (load) begin
      sr_d = i_dr_wdata;
    end else if (sample_ev) begin
      sr_d = {sr_q[6:0], data_in};
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      SMP_IDLE: begin
        if (start_master) begin
          state_d = SMP_MASTER;
        end else if (enter_slave) begin
          state_d = SMP_SLAVE;
        end
      end
      SMP_MASTER: begin
        if (fault || master_done || !master_on) begin
          state_d = SMP_IDLE;
        end
      end
      SMP_SLAVE: begin
        if (slave_done || !ss_low || !slave_on) begin
          state_d = SMP_IDLE;
        end
      end
      default: state_d = SMP_IDLE;
    endcase
  end

  // Serial clock: toggles on ticks while shifting, idle level otherwise
  always_comb begin
    sck_d = ctrl_q.clock_idle_level;
    if (in_master && state_d == SMP_MASTER) begin
      sck_d = m_tick ? !sck_q : sck_q;
    end
  end

  // Control: fault clears enable and master; a pending fault blocks setting them
  always_comb begin
    ctrl_d = ctrl_q;
    if (i_cr_wr) begin
      ctrl_d = i_cr_wdata;
      if (mode_fault_flag_q && !mf_armed_q) begin
        ctrl_d.port_enable_bit = 1'b0;
        ctrl_d.master_select_bit = 1'b0;
      end
    end
    if (fault) begin
      ctrl_d.port_enable_bit = 1'b0;
      ctrl_d.master_select_bit = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge rst_q) begin
    if (!rst_q) begin
      state_q <= SMP_IDLE;
      ctrl_q <= SMP_CTRL_RESET;
      sr_q <= SMP_DATA_RESET;
      out_q <= 1'b0;
      sck_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ctrl_q <= ctrl_d;
      sr_q <= sr_d;
      sck_q <= sck_d;
      if (load) begin
        out_q <= i_dr_wdata[7];
      end else if (shift_ev) begin
        out_q <= sr_q[7];
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge rst_q) begin
    if (!rst_q) begin
      edge_cnt_q <= SMP_EDGE_FIRST;
      samp_cnt_q <= SMP_SAMPLE_FIRST;
    end else if (in_idle) begin
      edge_cnt_q <= SMP_EDGE_FIRST;
      samp_cnt_q <= SMP_SAMPLE_FIRST;
    end else begin
      if (in_master && m_tick) begin
        edge_cnt_q <= edge_cnt_q + 1'b1;
      end
      if (sample_ev) begin
        samp_cnt_q <= samp_cnt_q + 1'b1;
      end
    end
  end

  // Flags: hardware set wins over the software clear sequence
  always_ff @(posedge i_ref_clk or negedge rst_q) begin
    if (!rst_q) begin
      done_q <= 1'b0;
      write_collision_flag_q <= 1'b0;
      mode_fault_flag_q <= 1'b0;
      armed_q <= 1'b0;
      mf_armed_q <= 1'b0;
    end else begin
      done_q <= done_ev || (done_q && !(armed_q && i_dr_rd));
      write_collision_flag_q <= collision || (write_collision_flag_q && !(armed_q && i_dr_rd));
      armed_q <= (i_sr_access && (done_q || write_collision_flag_q)) || (armed_q && !i_dr_rd);
      mode_fault_flag_q <= fault || (mode_fault_flag_q && !(mf_armed_q && i_cr_wr));
      mf_armed_q <= (i_sr_access && mode_fault_flag_q) || (mf_armed_q && !i_cr_wr);
    end
  end

  always_ff @(posedge i_ref_clk or negedge rst_q) begin
    if (!rst_q) begin
      irq_q <= 1'b0;
      busy_q <= 1'b0;
      sck_oe_q <= 1'b0;
      mosi_oe_q <= 1'b0;
      miso_oe_q <= 1'b0;
      rx_q <= SMP_DATA_RESET;
    end else begin
      irq_q <= ctrl_q.port_irq_enable && !i_global_irq_mask && (done_q || mode_fault_flag_q);
      busy_q <= !in_idle;
      sck_oe_q <= master_on;
      mosi_oe_q <= master_on;
      miso_oe_q <= slave_on && ss_low;
      if (f_out_valid) begin
        rx_q <= f_out_data;
      end
    end
  end

  assign o_rx_data = rx_q;
  assign o_ctrl = ctrl_q;
  assign o_status = '{xfer_done_flag: done_q, write_collision_flag: write_collision_flag_q,
                      mode_fault_flag: mode_fault_flag_q};
  assign o_irq = irq_q;
  assign o_busy = busy_q;
  assign o_sck = sck_q;
  assign o_sck_oe = sck_oe_q;
  assign o_mosi = out_q;
  assign o_mosi_oe = mosi_oe_q;
  assign o_miso = out_q;
  assign o_miso_oe = miso_oe_q;

  // Helper: serial clock toggles seen during the current master byte
  logic [4:0] tog_cnt_q;
  always_ff @(posedge i_ref_clk or negedge rst_q) begin
    if (!rst_q) begin
      tog_cnt_q <= SMP_DIV_ZERO;
    end else if (start_master) begin
      tog_cnt_q <= SMP_DIV_ZERO;
    end else if (in_master && (sck_d != sck_q)) begin
      tog_cnt_q <= tog_cnt_q + SMP_DIV_ONE;
    end
  end

  a_master_pulse_count: assert property (@(posedge i_ref_clk) disable iff (!rst_q)
    (master_done && !fault) |-> (tog_cnt_q == 5'h0F) && (sck_d == ctrl_q.clock_idle_level))
    else $error("master byte did not end after sixteen clock edges");

  a_sck_idle_hold: assert property (@(posedge i_ref_clk) disable iff (!rst_q)
    (in_idle && !start_master) [*2] |-> (o_sck == $past(ctrl_q.clock_idle_level)))
    else $error("serial clock moved while idle");

  a_start_loads: assert property (@(posedge i_ref_clk) disable iff (!rst_q)
    start_master |=> in_master && (sr_q == $past(i_dr_wdata)) && (o_mosi == $past(i_dr_wdata[7])))
    else $error("data write did not start and load a master byte");

  a_done_sets: assert property (@(posedge i_ref_clk) disable iff (!rst_q)
    done_ev |=> done_q ##1 (done_q || $past(armed_q && i_dr_rd)))
    else $error("transfer done flag not set at byte end");

  a_clear_needs_arm: assert property (@(posedge i_ref_clk) disable iff (!rst_q)
    (done_q && !armed_q && !i_sr_access) ##1 (i_dr_rd && !armed_q) |=> done_q)
    else $error("done flag cleared without a status access first");

  a_write_ignored: assert property (@(posedge i_ref_clk) disable iff (!rst_q)
    (done_q && !armed_q && i_dr_wr) |=> $stable(state_q) && !($rose(write_collision_flag_q)))
    else $error("data write accepted while done flag pending");

  a_collision_flag: assert property (@(posedge i_ref_clk) disable iff (!rst_q)
    (in_master && i_dr_wr && !wr_blocked && !fault) |=> write_collision_flag_q && (sr_q == $past(sr_d)))
    else $error("write during a transfer not flagged or disturbed shifting");

  a_fault_clears: assert property (@(posedge i_ref_clk) disable iff (!rst_q)
    fault |=> mode_fault_flag_q && !o_ctrl.port_enable_bit && !o_ctrl.master_select_bit ##1 !o_sck_oe)
    else $error("mode fault did not clear enable and master");

  a_irq_gate: assert property (@(posedge i_ref_clk) disable iff (!rst_q)
    (done_q && ctrl_q.port_irq_enable && !i_global_irq_mask) |=> o_irq)
    else $error("enabled completion interrupt not raised");

endmodule : smp_master_port

// ==== logic/smp_pkg.sv ====
// Shared constants and types of the serial master port
package smp_pkg;

  localparam int unsigned SMP_DATA_W = 8;
  localparam int unsigned SMP_FIFO_DEPTH = 16;

  // Serial clock edges per byte: eight pulses of two edges each
  localparam logic [3:0] SMP_EDGE_LAST = 4'hF;
  // Sample edges per byte, counted from zero
  localparam logic [2:0] SMP_SAMPLE_LAST = 3'h7;
  localparam logic [2:0] SMP_SAMPLE_FIRST = 3'h0;
  localparam logic [3:0] SMP_EDGE_FIRST = 4'h0;

  // Master serial clock divisors of the reference clock, one per rate setting
  // Fastest rate keeps three cycles per half period so MISO clears its two-flop sync
  localparam int unsigned SMP_SCK_DIV_0 = 6;
  localparam int unsigned SMP_SCK_DIV_1 = 8;
  localparam int unsigned SMP_SCK_DIV_2 = 16;
  localparam int unsigned SMP_SCK_DIV_3 = 32;
  localparam logic [4:0] SMP_HALF_0 = 5'(SMP_SCK_DIV_0 / 2);
  localparam logic [4:0] SMP_HALF_1 = 5'(SMP_SCK_DIV_1 / 2);
  localparam logic [4:0] SMP_HALF_2 = 5'(SMP_SCK_DIV_2 / 2);
  localparam logic [4:0] SMP_HALF_3 = 5'(SMP_SCK_DIV_3 / 2);
  localparam logic [4:0] SMP_DIV_ONE = 5'h01;
  localparam logic [4:0] SMP_DIV_ZERO = 5'h00;

  localparam logic [7:0] SMP_DATA_RESET = 8'h00;

  typedef struct packed {
    logic port_irq_enable;
    logic port_enable_bit;
    logic master_select_bit;
    logic clock_idle_level;
    logic clock_sample_phase;
    logic rate_select_hi;
    logic rate_select_lo;
  } smp_ctrl_s;

  typedef struct packed {
    logic xfer_done_flag;
    logic write_collision_flag;
    logic mode_fault_flag;
  } smp_status_s;

  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic ss_n;
  } smp_pins_s;

  localparam smp_ctrl_s SMP_CTRL_RESET = '0;
  localparam smp_status_s SMP_STATUS_RESET = '0;
  localparam smp_pins_s SMP_PINS_RESET = '{sck: 1'b0, mosi: 1'b0, miso: 1'b0, ss_n: 1'b1};

  typedef enum logic [1:0] {
    SMP_IDLE,
    SMP_MASTER,
    SMP_SLAVE
  } smp_state_e;

  function automatic logic [4:0] smp_half_count(input logic [1:0] sel);
    logic [4:0] half;
    half = SMP_HALF_0;
    case (sel)
      2'h1: half = SMP_HALF_1;
      2'h2: half = SMP_HALF_2;
      2'h3: half = SMP_HALF_3;
      default: half = SMP_HALF_0;
    endcase
    return half;
  endfunction : smp_half_count

endpackage : smp_pkg

// ==== logic/smp_fifo.sv ====
// Receive byte FIFO with valid and ready on both sides
`timescale 1ns/1ps
module smp_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int unsigned PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL_COUNT = (PW+1)'(DEPTH);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [PW:0] count_q;

  wire push = i_in_valid && o_in_ready;
  wire pop = o_out_valid && i_out_ready;

  assign o_in_ready = (count_q != FULL_COUNT);
  assign o_out_valid = (count_q != '0);
  assign o_out_data = mem_q[rd_ptr_q];

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == PTR_LAST) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == PTR_LAST) ? '0 : rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule : smp_fifo

// ==== logic/smp_rate_div.sv ====
// Serial clock half-period tick generator for master operation
`timescale 1ns/1ps
module smp_rate_div (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_run,
  input wire logic [1:0] i_rate_sel,
  output logic o_tick
);
  import smp_pkg::*;

  logic [4:0] cnt_q;
  wire [4:0] half = smp_half_count(i_rate_sel);
  wire at_end = (cnt_q == (half - SMP_DIV_ONE));

  assign o_tick = i_run && at_end;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= SMP_DIV_ZERO;
    end else if (!i_run || at_end) begin
      cnt_q <= SMP_DIV_ZERO;
    end else begin
      cnt_q <= cnt_q + SMP_DIV_ONE;
    end
  end
endmodule : smp_rate_div

// ==== testbench/smp_slave_model.sv ====
// Serial slave device facing the master port, shifting one byte per load
`timescale 1ns/1ps
module smp_slave_model (
  input wire logic i_sck,
  input wire logic i_mosi,
  input wire logic i_clock_idle_level,
  input wire logic i_clock_sample_phase,
  output logic o_miso,
  output logic [7:0] o_rx,
  output int o_edges
);
  logic [7:0] tx;
  int k;
  event done_ev;

  task automatic load(input logic [7:0] b);
    tx = b;
    k = 0;
    o_edges = 0;
    // Phase 0 shows the first bit before any edge; phase 1 not yet
    o_miso = i_clock_sample_phase ? ~o_miso : b[7];
  endtask : load

  initial begin
    o_miso = 1'b0;
    o_rx = 8'h00;
    k = 8;
  end

  always @(i_sck) begin
    o_edges++;
    if (((i_sck != i_clock_idle_level) ^ i_clock_sample_phase) && k < 8) begin
      o_rx = {o_rx[6:0], i_mosi};
      k++;
      if (k == 8) begin
        -> done_ev;
      end
    end else begin
      // After the last bit the line keeps being driven but toggles, so it shows no stale value
      o_miso = (k < 8) ? tx[7 - k] : ~o_miso;
    end
  end
endmodule : smp_slave_model

// ==== testbench/smp_master_port_tb.sv ====
// Self-checking bench of the serial master port
`timescale 1ns/1ps
module smp_master_port_tb;
  import smp_pkg::*;
  logic clk, nrst, dr_wr, dr_rd, sr_acc, cr_wr, mask, ss_n, b_sck, b_mosi;
  logic [7:0] wdata, rx_data, m_rx, b, s, got;
  smp_ctrl_s cr, ctrl;
  smp_status_s st;
  logic irq, busy, sck, sck_oe, mosi, mosi_oe, miso, miso_oe, m_miso;
  wire sck_w = sck_oe ? sck : b_sck;
  wire mosi_w = mosi_oe ? mosi : b_mosi;
  wire miso_w = miso_oe ? miso : m_miso;
  int fails, checks, m_edges;
  logic [31:0] rnd;
  logic [7:0] exp_q[$];
  logic [7:0] fifo_q[$];

  smp_master_port smp_master_port_i (.i_ref_clk(clk), .i_nrst(nrst), .i_dr_wr(dr_wr),
    .i_dr_wdata(wdata), .i_dr_rd(dr_rd), .i_sr_access(sr_acc), .i_cr_wr(cr_wr),
    .i_cr_wdata(cr), .i_global_irq_mask(mask), .o_rx_data(rx_data), .o_ctrl(ctrl),
    .o_status(st), .o_irq(irq), .o_busy(busy), .i_sck(sck_w), .o_sck(sck),
    .o_sck_oe(sck_oe), .i_mosi(mosi_w), .o_mosi(mosi), .o_mosi_oe(mosi_oe),
    .i_miso(miso_w), .o_miso(miso), .o_miso_oe(miso_oe), .i_ss_n(ss_n));

  smp_slave_model smp_slave_model_i (.i_sck(sck_w), .i_mosi(mosi_w),
    .i_clock_idle_level(ctrl.clock_idle_level), .i_clock_sample_phase(ctrl.clock_sample_phase), .o_miso(m_miso),
    .o_rx(m_rx), .o_edges(m_edges));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr

  task automatic rb(output logic [7:0] r);
    rnd = lfsr(rnd);
    r = rnd[7:0];
  endtask : rb

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] v);
    checks++;
    if (v !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, v);
    end
  endtask : chk

  task automatic report_and_stop;
    if (fails == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic pulse(ref logic p);
    @(negedge clk);
    p = 1'b1;
    @(negedge clk);
    p = 1'b0;
  endtask : pulse

  task automatic cfg(input smp_ctrl_s c);
    cr = c;
    pulse(cr_wr);
    repeat (3) @(negedge clk);
  endtask : cfg

  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (busy !== lvl && n < 1000) begin
      @(negedge clk);
      n++;
    end
    chk("busy", 8'(lvl), 8'(busy));
  endtask : wait_busy

  task automatic start(input logic [7:0] tb, input logic [7:0] sb);
    smp_slave_model_i.load(sb);
    exp_q.push_back(tb);
    wdata = tb;
    pulse(dr_wr);
    wait_busy(1'b1);
  endtask : start

  task automatic finish;
    wait_busy(1'b0);
    repeat (3) @(negedge clk);
    chk("edges", 8'h10, 8'(m_edges));
    chk("sck idle", 8'(ctrl.clock_idle_level), 8'(sck));
    chk("done", 8'h01, 8'(st.xfer_done_flag));
  endtask : finish

  // Each byte seen by the slave is compared with the oldest byte written
  initial begin
    forever begin
      @(smp_slave_model_i.done_ev);
      chk("mosi byte", exp_q.pop_front(), m_rx);
    end
  end

  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    report_and_stop();
  end

  initial begin
    rnd = 32'h4808FDF9;
    {nrst, dr_wr, dr_rd, sr_acc, cr_wr, mask, b_sck, b_mosi} = '0;
    ss_n = 1'b1;
    wdata = 8'h00;
    cr = '0;
    fails = 0;
    checks = 0;
    repeat (10) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    chk("status", 8'h00, 8'(st));
    chk("ctrl", 8'h00, 8'(ctrl));
    // Every timing mode and every rate, interrupt enable and mask varied
    for (int i = 0; i < 4; i++) begin
      rb(b);
      rb(s);
      mask = i[1];
      cfg('{port_irq_enable: i[0], port_enable_bit: 1'b1, master_select_bit: 1'b1,
        clock_idle_level: i[0], clock_sample_phase: i[1], rate_select_hi: ~i[1],
        rate_select_lo: ~i[0]});
      chk("sck oe", 8'h01, 8'(sck_oe));
      start(b, s);
      finish();
      chk("rx", s, rx_data);
      chk("irq", 8'(i[0] & ~i[1]), 8'(irq));
      pulse(dr_rd);
      repeat (2) @(negedge clk);
      chk("done", 8'h01, 8'(st.xfer_done_flag));
      pulse(sr_acc);
      pulse(dr_rd);
      repeat (2) @(negedge clk);
      chk("status", 8'h00, 8'(st));
    end
    // Write during a transfer, then a write while done is pending
    mask = 1'b0;
    cfg('{port_irq_enable: 1'b1, port_enable_bit: 1'b1, master_select_bit: 1'b1,
      default: 1'b0});
    rb(b);
    rb(s);
    start(b, s);
    wdata = ~b;
    pulse(dr_wr);
    repeat (2) @(negedge clk);
    chk("status", 8'h02, 8'(st));
    chk("irq", 8'h00, 8'(irq));
    finish();
    wdata = b;
    pulse(dr_wr);
    repeat (6) @(negedge clk);
    chk("busy", 8'h00, 8'(busy));
    chk("status", 8'h06, 8'(st));
    pulse(sr_acc);
    pulse(dr_rd);
    repeat (2) @(negedge clk);
    chk("status", 8'h00, 8'(st));
    // Fill the receive FIFO without reading, then drain it
    for (int i = 0; i < 16; i++) begin
      rb(b);
      rb(s);
      fifo_q.push_back(s);
      if (i > 0)
        pulse(sr_acc);
      start(b, s);
      finish();
      chk("rx head", fifo_q[0], rx_data);
    end
    pulse(sr_acc);
    pulse(dr_wr);
    repeat (6) @(negedge clk);
    chk("busy", 8'h00, 8'(busy));
    while (fifo_q.size() > 0) begin
      chk("rx fifo", fifo_q.pop_front(), rx_data);
      pulse(dr_rd);
      repeat (2) @(negedge clk);
    end
    chk("status", 8'h00, 8'(st));
    // Select input pulled low on an enabled master
    cfg('{port_irq_enable: 1'b1, port_enable_bit: 1'b1, master_select_bit: 1'b1,
      default: 1'b0});
    ss_n = 1'b0;
    repeat (5) @(negedge clk);
    chk("status", 8'h01, 8'(st));
    chk("ctrl", 8'h40, 8'(ctrl));
    chk("irq", 8'h01, 8'(irq));
    ss_n = 1'b1;
    pulse(sr_acc);
    cfg('{port_enable_bit: 1'b1, default: 1'b0});
    chk("status", 8'h00, 8'(st));
    chk("ctrl", 8'h20, 8'(ctrl));
    // Slave byte clocked by the bench at the link clock rate
    rb(b);
    rb(s);
    wdata = s;
    pulse(dr_wr);
    @(negedge clk);
    ss_n = 1'b0;
    repeat (6) @(negedge clk);
    for (int j = 7; j >= 0; j--) begin
      b_mosi = b[j];
      #160;
      b_sck = 1'b1;
      got[j] = miso_w;
      #160;
      b_sck = 1'b0;
    end
    repeat (6) @(negedge clk);
    ss_n = 1'b1;
    repeat (4) @(negedge clk);
    chk("slave rx", b, rx_data);
    chk("slave tx", s, got);
    chk("status", 8'h04, 8'(st));
    report_and_stop();
  end
endmodule : smp_master_port_tb
